// ===== traverse_pkg.sv
// constants shared by the traverse frequency superimposer and its helpers
// assumes a single 25 MHz clock; frequencies are plain unsigned codes
package traverse_pkg;

   // clock and time base
   localparam int CLK_PERIOD_NS  = 40;
   localparam int TIME_UNIT_NS   = 10_000_000;   // setting unit 0.01 s
   localparam int UNIT_CYCLES    = TIME_UNIT_NS / CLK_PERIOD_NS;
   localparam int PCT_DIVISOR    = 10000;        // setting unit 0.01 %

   // operating modes
   localparam logic [1:0] MODE_OFF    = 2'h0;
   localparam logic [1:0] MODE_MASTER = 2'h1;
   localparam logic [1:0] MODE_SLAVE  = 2'h2;

   // setting ranges, in setting units
   localparam logic [14:0] TIME_MIN = 15'h0001;  // 0.01 s
   localparam logic [14:0] TIME_MAX = 15'h7d00;  // 320.00 s
   localparam logic [12:0] PCT_MIN  = 13'h0001;  // 0.01 %
   localparam logic [12:0] PCT_MAX  = 13'h1388;  // 50.00 %

   // reset values
   localparam logic [14:0] ACC_RST  = 15'h01f4;  // 5 s
   localparam logic [14:0] DEC_RST  = 15'h01f4;  // 5 s
   localparam logic [12:0] AMP_RST  = 13'h03e8;  // 10 %
   localparam logic [12:0] STEP_RST = 13'h0001;  // 0.01 %
   localparam logic [1:0]  SEL_RST  = 2'h0;

   // register byte offsets
   localparam logic [7:0] OFS_MODE   = 8'h00;
   localparam logic [7:0] OFS_ACC    = 8'h04;
   localparam logic [7:0] OFS_DEC    = 8'h08;
   localparam logic [7:0] OFS_AMP    = 8'h0c;
   localparam logic [7:0] OFS_STEP   = 8'h10;
   localparam logic [7:0] OFS_HSSEL  = 8'h14;
   localparam logic [7:0] OFS_FMIN   = 8'h18;
   localparam logic [7:0] OFS_FMAX   = 8'h1c;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam logic [7:0] OFS_OFFSET = 8'h24;

   // status field positions
   localparam int STAT_ACTIVE = 0;
   localparam int STAT_DIRUP  = 1;
   localparam int STAT_HOLD   = 2;
   localparam int STAT_HSOUT  = 3;
   localparam int STAT_WAIT   = 4;

endpackage

// ===== pct_scale.sv
// scales a frequency code by a percentage given in 0.01 % units
// assumes pct never exceeds 50.00 %, so the result fits the input width
`timescale 1ns/100ps

module pct_scale
#(
   parameter int FW = 24
)
(
   input  wire logic [FW-1:0] value,
   input  wire logic [12:0]   pct,
   output logic      [FW-1:0] scaled
);

   localparam logic [FW+12:0] DIV = (FW+13)'(traverse_pkg::PCT_DIVISOR);

   logic [FW+12:0] prod;

   always_comb
   begin
      prod   = (FW+13)'(value) * (FW+13)'(pct);
      scaled = FW'(prod / DIV);
   end

endmodule // pct_scale

// ===== rate_stepper.sv
// error-accumulating pacer: emits incr ticks for every period cycles
// one tick per cycle at most, so very steep slopes saturate at clk rate
`timescale 1ns/100ps

module rate_stepper
#(
   parameter int IW = 24,
   parameter int PW = 34
)
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          run,
   input  wire logic [IW-1:0] incr,
   input  wire logic [PW-1:0] period,
   output logic               tick
);

   typedef struct packed {
      logic [PW:0] acc;
      logic        tick;
   } state_s;

   state_s q_r;
   state_s q_nxt;
   logic [PW:0] sum;

   always_comb
   begin
      q_nxt      = q_r;
      sum        = q_r.acc + (PW+1)'(incr);
      q_nxt.tick = 1'b0;
      if (!run)
         q_nxt.acc = '0;
      else if (sum >= {1'b0, period})
      begin
         q_nxt.acc  = sum - {1'b0, period};
         q_nxt.tick = 1'b1;
      end
      else
         q_nxt.acc = sum;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         q_r <= '0;
      else
         q_r <= q_nxt;
   end

   assign tick = q_r.tick;

endmodule // rate_stepper

// ===== traverse_superimposer.sv
// traverse frequency superimposer with a classic wishbone register slave
// assumes base_freq comes from the ordinary ramp generator and that all
// inputs are synchronous to clk
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/100ps

// What this block does
// [RL1] while enabled a triangle offset rides on the output frequency, its rising and falling slopes set by the traverse accel and decel times.
// [RL2] as master the offset ramps linearly to the amplitude limit (0.01..50.00 %, reset 10 %) and then turns round.
// [RL3] each turn-round applies an immediate proportional step (0.01..50.00 %, reset 0.01 %) to the offset.
// [RL4] a master reports each change of direction by switching its handshake line.
// [RL5] as slave the offset moves with the master's slope magnitude but the opposite sign.
// [RL6] a slave that reaches the limit before a handshake switch holds its offset until the switch comes.
// [RL7] a slave that sees a handshake switch before the limit turns round at once.
// [RL8] mode 0 is off, 1 is master and 2 is slave.
// [RL9] traversing starts only once the reference frequency is first reached; until then the ordinary ramps drive the output.
// [RL10] while traversing the traverse accel and decel times (0.01..320.00 s, reset 5 s) pace the slopes.
// [RL11] while traversing the output is clamped between the minimum and maximum frequency.
// [RL12] traverse settings cannot be changed while traversing is in progress.
// [RL13] a selector picks which input carries the incoming handshake.
// [RL14] the traverse output is added to the reference frequency value; the code adds it to base_freq, the ramp output.
// [RL15] amplitude limit and step are percentages of the reference frequency.
// [RL16] the handshake is a level toggled once per turn-round, each change counted as one switch event.
module traverse_superimposer
#(
   parameter int FW          = 24,
   parameter int HS_N        = 4,
   parameter int UNIT_CYCLES = traverse_pkg::UNIT_CYCLES
)
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   input  wire logic          run,
   input  wire logic [FW-1:0] ref_freq,
   input  wire logic [FW-1:0] base_freq,
   input  wire logic [HS_N-1:0] hs_src,
   output logic               hs_out,
   output logic               traverse_active,
   output logic [FW:0]        traverse_out,
   output logic [FW-1:0]      freq_out
);

   localparam int PW = 34;

   generate
      if (FW < 8 || FW > 31 || HS_N < 1 || HS_N > 4 || UNIT_CYCLES < 1)
         $error("traverse_superimposer: unsupported parameter values");
   endgenerate

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT_REF, ST_TRAVERSE} state_e;

   typedef struct packed {
      state_e             st;
      logic               dir_up;
      logic               hold;
      logic               hs_out;
      logic               hs_prev;
      logic signed [FW:0] offset;
      logic [1:0]         mode;
      logic [14:0]        acc_t;
      logic [14:0]        dec_t;
      logic [12:0]        amp_p;
      logic [12:0]        step_p;
      logic [1:0]         hs_sel;
      logic [FW-1:0]      fmin;
      logic [FW-1:0]      fmax;
      logic [FW-1:0]      fout;
      logic               ack;
      logic [31:0]        rdata;
   } state_s;

   state_s q_r;
   state_s q_nxt;

   logic [FW-1:0] amp_abs;
   logic [FW-1:0] step_abs;
   logic          tick;
   logic [PW-1:0] period;
   logic          hs_lvl;
   logic          hs_evt;
   logic          req;
   logic [31:0]   wd;
   logic signed [FW+1:0] amp_s;
   logic signed [FW+1:0] step_s;
   logic signed [FW+1:0] off_w;
   logic signed [FW+1:0] sum;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            r[i*8 +: 8] = new_v[i*8 +: 8];
      return r;
   endfunction

   function automatic logic [31:0] lim(input logic [31:0] v,
                                       input logic [31:0] lo,
                                       input logic [31:0] hi);
      if (v < lo)
         return lo;
      else if (v > hi)
         return hi;
      return v;
   endfunction

   function automatic logic [31:0] reg_val(input state_s s,
                                           input logic [7:0] adr);
      logic [31:0] r;
      r = '0;
      unique case (adr)
         traverse_pkg::OFS_MODE:   r = 32'(s.mode);
         traverse_pkg::OFS_ACC:    r = 32'(s.acc_t);
         traverse_pkg::OFS_DEC:    r = 32'(s.dec_t);
         traverse_pkg::OFS_AMP:    r = 32'(s.amp_p);
         traverse_pkg::OFS_STEP:   r = 32'(s.step_p);
         traverse_pkg::OFS_HSSEL:  r = 32'(s.hs_sel);
         traverse_pkg::OFS_FMIN:   r = 32'(s.fmin);
         traverse_pkg::OFS_FMAX:   r = 32'(s.fmax);
         traverse_pkg::OFS_STATUS:
         begin
            r[traverse_pkg::STAT_ACTIVE] = (s.st == ST_TRAVERSE);
            r[traverse_pkg::STAT_DIRUP]  = s.dir_up;
            r[traverse_pkg::STAT_HOLD]   = s.hold;
            r[traverse_pkg::STAT_HSOUT]  = s.hs_out;
            r[traverse_pkg::STAT_WAIT]   = (s.st == ST_WAIT_REF);
         end
         traverse_pkg::OFS_OFFSET: r = 32'(signed'(s.offset));
         default:                  r = '0;
      endcase
      return r;
   endfunction

   // limits follow the reference so the triangle scales with speed
   pct_scale #(.FW(FW)) u_amp
   (
      .value  (ref_freq),
      .pct    (q_r.amp_p),
      .scaled (amp_abs)
   ); // [RL15]

   pct_scale #(.FW(FW)) u_step
   (
      .value  (ref_freq),
      .pct    (q_r.step_p),
      .scaled (step_abs)
   ); // [RL15]

   // rising slope paced by accel time, falling by decel time
   assign period = q_r.dir_up ? PW'(q_r.acc_t) * PW'(UNIT_CYCLES)
                              : PW'(q_r.dec_t) * PW'(UNIT_CYCLES); // [RL10]

   rate_stepper #(.IW(FW), .PW(PW)) u_pace
   (
      .clk    (clk),
      .rst_n  (rst_n),
      .run    (q_r.st == ST_TRAVERSE && !q_r.hold),
      .incr   (amp_abs),
      .period (period),
      .tick   (tick)
   ); // [RL1]

   assign hs_lvl = hs_src[q_r.hs_sel];                   // [RL13]
   assign hs_evt = (hs_lvl != q_r.hs_prev);               // [RL16]
   assign req    = wb_cyc_i && wb_stb_i && !q_r.ack;
   assign wd     = merge(reg_val(q_r, wb_adr_i), wb_dat_i, wb_sel_i);

   always_comb
   begin
      q_nxt   = q_r;
      amp_s   = signed'({2'b00, amp_abs});
      step_s  = signed'({2'b00, step_abs});
      off_w   = (FW+2)'(q_r.offset);
      sum     = signed'({2'b00, base_freq}) + off_w;
      q_nxt.hs_prev = hs_lvl;
      q_nxt.ack     = req;
      q_nxt.rdata   = q_r.rdata;

      unique case (q_r.st)
         ST_IDLE:
         begin
            q_nxt.offset = '0;
            q_nxt.hold   = 1'b0;
            if (run && q_r.mode != traverse_pkg::MODE_OFF)   // [RL8]
               q_nxt.st = ST_WAIT_REF;
         end
         ST_WAIT_REF:
         begin
            if (!run || q_r.mode == traverse_pkg::MODE_OFF)
               q_nxt.st = ST_IDLE;
            else if (base_freq == ref_freq)                  // [RL9]
            begin
               q_nxt.st     = ST_TRAVERSE;
               q_nxt.offset = '0;
               // slave starts against the master's first slope
               q_nxt.dir_up = (q_r.mode == traverse_pkg::MODE_MASTER); // [RL5]
            end
         end
         ST_TRAVERSE:
         begin
            if (!run)
               q_nxt.st = ST_IDLE;
            else if (q_r.mode == traverse_pkg::MODE_MASTER)
            begin
               if (q_r.dir_up && off_w >= amp_s)                // [RL2]
               begin
                  q_nxt.dir_up = 1'b0;
                  q_nxt.offset = (FW+1)'(amp_s - step_s);       // [RL3]
                  q_nxt.hs_out = ~q_r.hs_out;                   // [RL4]
               end
               else if (!q_r.dir_up && off_w <= -amp_s)         // [RL2]
               begin
                  q_nxt.dir_up = 1'b1;
                  q_nxt.offset = (FW+1)'(step_s - amp_s);       // [RL3]
                  q_nxt.hs_out = ~q_r.hs_out;                   // [RL4]
               end
               else if (tick)
                  q_nxt.offset = q_r.dir_up ? q_r.offset + 1'b1
                                            : q_r.offset - 1'b1; // [RL1]
            end
            else
            begin
               if (hs_evt)                                      // [RL7]
               begin
                  q_nxt.dir_up = ~q_r.dir_up;
                  q_nxt.hold   = 1'b0;
                  q_nxt.offset = q_r.dir_up ? (FW+1)'(off_w - step_s)
                                            : (FW+1)'(off_w + step_s); // [RL3]
               end
               else if ((q_r.dir_up && off_w >= amp_s) ||
                        (!q_r.dir_up && off_w <= -amp_s))
                  q_nxt.hold = 1'b1;                            // [RL6]
               else if (tick)
                  q_nxt.offset = q_r.dir_up ? q_r.offset + 1'b1
                                            : q_r.offset - 1'b1; // [RL5]
            end
         end
         default:
            q_nxt.st = ST_IDLE;
      endcase

      // output: reference path plus offset, clamped only while traversing
      if (q_r.st != ST_TRAVERSE)
         q_nxt.fout = base_freq;                                // [RL9]
      else if (sum < signed'({2'b00, q_r.fmin}))
         q_nxt.fout = q_r.fmin;                                 // [RL11]
      else if (sum > signed'({2'b00, q_r.fmax}))
         q_nxt.fout = q_r.fmax;                                 // [RL11]
      else
         q_nxt.fout = FW'(sum);                                 // [RL14]

      // register access; writes land on the edge that raises ack
      if (req && !wb_we_i)
         q_nxt.rdata = reg_val(q_r, wb_adr_i);
      if (req && wb_we_i)
      begin
         if (q_r.st != ST_TRAVERSE)                             // [RL12]
         begin
            unique case (wb_adr_i)
               traverse_pkg::OFS_MODE:
                  if (wd[1:0] != 2'h3)
                     q_nxt.mode = wd[1:0];                      // [RL8]
               traverse_pkg::OFS_ACC:
                  q_nxt.acc_t = 15'(lim(wd, 32'(traverse_pkg::TIME_MIN),
                                        32'(traverse_pkg::TIME_MAX)));
               traverse_pkg::OFS_DEC:
                  q_nxt.dec_t = 15'(lim(wd, 32'(traverse_pkg::TIME_MIN),
                                        32'(traverse_pkg::TIME_MAX)));
               traverse_pkg::OFS_AMP:
                  q_nxt.amp_p = 13'(lim(wd, 32'(traverse_pkg::PCT_MIN),
                                        32'(traverse_pkg::PCT_MAX)));
               traverse_pkg::OFS_STEP:
                  q_nxt.step_p = 13'(lim(wd, 32'(traverse_pkg::PCT_MIN),
                                         32'(traverse_pkg::PCT_MAX)));
               traverse_pkg::OFS_HSSEL:
                  q_nxt.hs_sel = wd[1:0];                       // [RL13]
               default:
                  q_nxt.hs_sel = q_r.hs_sel;
            endcase
         end
         // frequency limits stay writable at any time
         if (wb_adr_i == traverse_pkg::OFS_FMIN)
            q_nxt.fmin = wd[FW-1:0];
         if (wb_adr_i == traverse_pkg::OFS_FMAX)
            q_nxt.fmax = wd[FW-1:0];
      end
      // an out-of-range selector would pick an absent input
      if (int'(q_nxt.hs_sel) >= HS_N)
         q_nxt.hs_sel = q_r.hs_sel;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         q_r        <= '0;
         q_r.st     <= ST_IDLE;
         q_r.mode   <= traverse_pkg::MODE_OFF;
         q_r.acc_t  <= traverse_pkg::ACC_RST;
         q_r.dec_t  <= traverse_pkg::DEC_RST;
         q_r.amp_p  <= traverse_pkg::AMP_RST;
         q_r.step_p <= traverse_pkg::STEP_RST;
         q_r.hs_sel <= traverse_pkg::SEL_RST;
         q_r.fmax   <= '1;
      end
      else
         q_r <= q_nxt;
   end

   assign wb_dat_o        = q_r.rdata;
   assign wb_ack_o        = q_r.ack;
   assign hs_out          = q_r.hs_out;
   assign traverse_active = (q_r.st == ST_TRAVERSE);
   assign traverse_out    = q_r.offset;
   assign freq_out        = q_r.fout;

endmodule // traverse_superimposer

// ===== traverse_superimposer_props.sv
// port checks of the traverse superimposer
// bound from the testbench top; one clock, synchronous reset
`timescale 1ns/100ps
module traverse_props
#(
   parameter int FW   = 24,
   parameter int HS_N = 4
)
(
   input wire logic          clk,
   input wire logic          rst_n,
   input wire logic          wb_cyc_i,
   input wire logic          wb_stb_i,
   input wire logic          wb_ack_o,
   input wire logic          run,
   input wire logic [FW-1:0] ref_freq,
   input wire logic [FW-1:0] base_freq,
   input wire logic          hs_out,
   input wire logic          traverse_active,
   input wire logic [FW:0]   traverse_out,
   input wire logic [FW-1:0] freq_out
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic req;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   a_ack_once:
      assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_ack_answer:
      assert property (req |=> wb_ack_o)
      else $error("request not answered");
   a_ack_cause:
      assert property (!req |=> !wb_ack_o)
      else $error("ack without request");
   a_reset_clear:
      assert property (disable iff (1'b0) !rst_n |=> !wb_ack_o && !hs_out
         && !traverse_active && traverse_out == '0 && freq_out == '0)
      else $error("outputs not cleared by reset");
   a_idle_pass:
      assert property (!traverse_active |=> freq_out == $past(base_freq))
      else $error("output differs from ramp while not traversing");
   a_start_cause:
      assert property ($rose(traverse_active)
         |-> $past(run && base_freq == ref_freq))
      else $error("traverse began without reference match");
   a_start_zero:
      assert property ($rose(traverse_active) |-> traverse_out == '0)
      else $error("traverse began with an offset");
   a_run_stop:
      assert property (!run |=> !traverse_active)
      else $error("traverse kept on without run");
   a_hs_active:
      assert property ($past(rst_n) && $changed(hs_out)
         |-> $past(traverse_active))
      else $error("handshake switched outside traverse");
endmodule // traverse_props

// ===== hs_peer.sv
// peer drive unit on the handshake link
// toggles its level on command and counts reversals it is told of
`timescale 1ns/100ps
module hs_peer
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       toggle,
   input  wire logic       far_hs,
   output logic            hs_lvl,
   output logic [7:0]      seen_cnt
);
   logic far_r;
   always_ff @(posedge clk)
   begin
      far_r <= far_hs;
      if (!rst_n)
      begin
         hs_lvl   <= 1'b0;
         seen_cnt <= 8'h00;
      end
      else
      begin
         if (toggle)
            hs_lvl <= ~hs_lvl;
         if (far_hs != far_r)
            seen_cnt <= seen_cnt + 8'h01;
      end
   end
endmodule // hs_peer

// ===== tb_traverse_superimposer.sv
// bench: register setup, master, slave against hs_peer, off mode
// one 25 MHz clock; the checker is bound at the foot
`timescale 1ns/100ps
module tb_traverse_superimposer;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cyc = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic        run = 1'b0;
   logic [23:0] ref_f = 24'h0003e8;
   logic [23:0] base_f = 24'h000384;
   logic [1:0]  hs_misc = 2'h0;
   logic        tog = 1'b0;
   logic        peer_lvl;
   logic [7:0]  peer_cnt;
   logic [31:0] dat_o;
   logic        ack;
   logic        hs_out;
   logic        act;
   logic [24:0] t_out;
   logic [23:0] f_out;
   int          error_cnt = 0;
   int          total_checks = 0;

   always #20 clk = ~clk;

   traverse_superimposer #(.UNIT_CYCLES(4)) u_dut
   (
      .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .run(run), .ref_freq(ref_f),
      .base_freq(base_f), .hs_src({hs_misc, peer_lvl, 1'b0}),
      .hs_out(hs_out), .traverse_active(act), .traverse_out(t_out),
      .freq_out(f_out)
   );
   hs_peer u_peer
   (
      .clk(clk), .rst_n(rst_n), .toggle(tog), .far_hs(hs_out),
      .hs_lvl(peer_lvl), .seen_cnt(peer_cnt)
   );

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // holds the request until ack is sampled, then drops it
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      rdat = dat_o;
      cyc <= 1'b0;
      // a missing ack ends the run here rather than hanging later steps
      if (n >= 20)
      begin
         chk(32'h0, 32'h1);
         conclude();
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   function automatic logic cond(input int k, input int v);
      case (k)
         0: return act === 1'b1;
         1: return hs_out !== v[0];
         default: return $signed(t_out) >= v;
      endcase
   endfunction
   task automatic waitc(input int k, input int v, output int n);
      for (n = 0; n < 3000 && !cond(k, v); n++)
         @(posedge clk);
      if (n >= 3000)
      begin
         chk(32'h0, 32'h1);
         conclude();
      end
   endtask
   // o is the offset seen just before the peer switches its level
   task automatic flip_peer(output int o);
      o = $signed(t_out);
      tog <= 1'b1;
      @(posedge clk);
      tog <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic setup(input logic [1:0] m);
      int n;
      wb(1'b1, traverse_pkg::OFS_MODE, 32'(m));
      wb(1'b1, traverse_pkg::OFS_ACC, 32'h64);
      wb(1'b1, traverse_pkg::OFS_DEC, 32'h64);
      wb(1'b1, traverse_pkg::OFS_AMP, 32'h3e8);
      wb(1'b1, traverse_pkg::OFS_STEP, 32'h1f4);
      run <= 1'b1;
      repeat (20) @(posedge clk);
      wb(1'b0, traverse_pkg::OFS_STATUS, 32'h0);
      chk(32'({act, rdat[traverse_pkg::STAT_WAIT]}), 32'h1);
      base_f <= ref_f;
      waitc(0, 0, n);
   endtask

   task automatic t_reset();
      rd_chk(traverse_pkg::OFS_MODE, 32'h0);
      rd_chk(traverse_pkg::OFS_ACC, 32'(traverse_pkg::ACC_RST));
      rd_chk(traverse_pkg::OFS_AMP, 32'(traverse_pkg::AMP_RST));
      rd_chk(traverse_pkg::OFS_STEP, 32'(traverse_pkg::STEP_RST));
      rd_chk(8'h40, 32'h0);
      rd_chk(traverse_pkg::OFS_FMAX, 32'h00ffffff);
      wb(1'b1, traverse_pkg::OFS_DEC, 32'h0);
      rd_chk(traverse_pkg::OFS_DEC, 32'h1);
      wb(1'b1, traverse_pkg::OFS_AMP, 32'h2710);
      rd_chk(traverse_pkg::OFS_AMP, 32'h1388);
   endtask
   // amplitude 100 and step 50 codes at a reference of 1000
   task automatic t_master();
      int n;
      int o;
      setup(traverse_pkg::MODE_MASTER);
      waitc(1, 0, n);
      chk(32'(n > 390 && n < 410), 32'h1);
      chk(32'($signed(t_out)), 32'd50);
      rd_chk(traverse_pkg::OFS_STATUS, 32'h9);
      wb(1'b1, traverse_pkg::OFS_AMP, 32'h7d0);
      rd_chk(traverse_pkg::OFS_AMP, 32'h3e8);
      o = $signed(t_out);
      @(posedge clk);
      chk(32'(f_out), 32'(1000 + o));
      wb(1'b1, traverse_pkg::OFS_FMIN, 32'h3d4);
      wb(1'b1, traverse_pkg::OFS_FMAX, 32'h406);
      waitc(1, 1, n);
      chk(32'($signed(t_out)), 32'(-50));
      chk(32'(f_out), 32'h3d4);
      waitc(2, 40, n);
      repeat (2) @(posedge clk);
      chk(32'(f_out), 32'h406);
      chk(32'(peer_cnt), 32'h2);
      run <= 1'b0;
      base_f <= 24'h000384;
   endtask
   task automatic t_slave();
      int n;
      int o;
      wb(1'b1, traverse_pkg::OFS_HSSEL, 32'h1);
      wb(1'b1, traverse_pkg::OFS_FMIN, 32'h0);
      rd_chk(traverse_pkg::OFS_HSSEL, 32'h1);
      setup(traverse_pkg::MODE_SLAVE);
      hs_misc <= 2'h3;
      repeat (200) @(posedge clk);
      chk(32'($signed(t_out) < 0), 32'h1);
      repeat (400) @(posedge clk);
      wb(1'b0, traverse_pkg::OFS_STATUS, 32'h0);
      chk(32'(rdat[traverse_pkg::STAT_HOLD]), 32'h1);
      chk(32'($signed(t_out)), 32'(-100));
      rd_chk(traverse_pkg::OFS_OFFSET, 32'hffffff9c);
      flip_peer(o);
      chk(32'($signed(t_out) inside {-50, -49}), 32'h1);
      waitc(2, 10, n);
      flip_peer(o);
      chk(32'($signed(t_out) inside {[o-50:o-48]}), 32'h1);
      run <= 1'b0;
   endtask
   task automatic t_off();
      wb(1'b1, traverse_pkg::OFS_MODE, 32'h0);
      wb(1'b1, traverse_pkg::OFS_MODE, 32'h3);
      rd_chk(traverse_pkg::OFS_MODE, 32'h0);
      run <= 1'b1;
      base_f <= ref_f;
      repeat (20) @(posedge clk);
      chk(32'(act), 32'h0);
   endtask

   initial
   begin
      #(40 * 20000);
      error_cnt++;
      conclude();
   end
   initial
   begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_master();
      t_slave();
      t_off();
      conclude();
   end
endmodule // tb_traverse_superimposer

bind traverse_superimposer traverse_props #(.FW(FW), .HS_N(HS_N)) u_props
(
   .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .run, .ref_freq,
   .base_freq, .hs_out, .traverse_active, .traverse_out, .freq_out
);
